// ==== shared/spfa_pkg.sv ====
/*
 * Constants for the self-programming flash addressing front end: address
 * split, boot-size decode table, region limits, control patterns and timing.
 * Assumes a 20 MHz system clock and a calibrated RC oscillator tick input.
 */
// Functional notes
// - boot fuse pair selects boot section start
// - words below 1C00 blocked while writing
// - erase or write lasts 3.7 to 4.5 ms
// - program timing counts calibrated oscillator ticks
// - write in progress survives system reset
// - thirteen bit word counter addresses flash
// - sixty four word pages, low six bits
// - pointer is counter shifted, top bits ignored
// - page index from pointer bits 13:7
// - buffer word from pointer bits 6:1
// - pointer bit zero picks read byte
// - busy flag holds until region reenabled; reset outside programming also clears it
// - only blocked region readable during programming
// - pattern X0000011 plus store erases page
// - pattern 00000001 plus store loads buffer
// - pattern X0000101 plus store writes page
// - busy flag cleared only by reenable; reset outside programming also clears it
package spfa_pkg;
   // =====================================================
   // address layout
   localparam int PC_W       = 13;   // word counter width
   localparam int WORD_IDX_W = 6;    // in-page word index width
   localparam int PAGE_IDX_W = 7;    // page index width
   localparam int PAGE_WORDS = 64;   // words per page
   localparam int PTR_W      = 16;   // address pointer width
   localparam int PTR_TOP    = 13;   // pointer_counter_top_bit
   localparam int PTR_PAGE_LO = 7;   // pointer page index low bit
   localparam int PTR_WORD_TOP = 6;  // pointer_in_page_top_bit
   localparam int PTR_WORD_LO = 1;   // pointer word index low bit
   localparam int PTR_BYTE_SEL = 0;  // byte select bit for loads

   // =====================================================
   // boot section starts per fuse pair
   localparam logic [12:0] BOOT_START_128  = 13'h1F80;
   localparam logic [12:0] BOOT_START_256  = 13'h1F00;
   localparam logic [12:0] BOOT_START_512  = 13'h1E00;
   localparam logic [12:0] BOOT_START_1024 = 13'h1C00;
   localparam logic [12:0] BLOCKED_DURING_WRITE_REGION_START      = 13'h1C00;

   // =====================================================
   // control register patterns (bit 7 ignored on erase/write)
   localparam logic [6:0] CMD_ERASE   = 7'h03;
   localparam logic [6:0] CMD_WRITE   = 7'h05;
   localparam logic [7:0] CMD_LOAD    = 8'h01;
   localparam logic [6:0] CMD_REEN    = 7'h11;
   localparam logic [6:0] CMD_LOCKSET = 7'h09;
   localparam int         ENABLE_BIT  = 0;
   localparam int         BUSY_BIT    = 6;
   localparam int         CMD_WINDOW  = 4;   // store must follow within four cycles

   // =====================================================
   // timing, in microseconds of calibrated oscillator ticks (1 MHz)
   localparam int PROG_MIN_US  = 3700;
   localparam int PROG_MAX_US  = 4500;
   localparam int OSC_TICK_NS  = 1000;
   localparam int PROG_TICKS   = ((PROG_MIN_US * 1000) + OSC_TICK_NS - 1) / OSC_TICK_NS;
endpackage : spfa_pkg

// ==== hdl/spfa_page_buf.sv ====
/*
 * Temporary page buffer: 64 words, written one at a time, erased as a whole.
 * Assumes the controller never writes and erases in the same cycle.
 */
`timescale 1ns/1ps
module spfa_page_buf #(
   parameter int WORDS = spfa_pkg::PAGE_WORDS,
   parameter int IDX_W = spfa_pkg::WORD_IDX_W
) (
   input  wire logic             i_clk,
   input  wire logic             i_sys_rst,
   input  wire logic             i_ce,
   input  wire logic             i_wr,       // store one word
   input  wire logic             i_clr,      // auto erase
   input  wire logic [IDX_W-1:0] i_idx,      // word slot
   input  wire logic [15:0]      i_data,     // word to keep
   input  wire logic [IDX_W-1:0] i_rd_idx,   // readout slot
   output logic      [15:0]      o_rd_data   // registered readout
);
   // =====================================================
   // storage: erased flash word reads as all ones
   logic [15:0] mem_q [WORDS];

   // buffer storage and registered read port
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         for (int k = 0; k < WORDS; k++) begin
            mem_q[k] <= 16'hFFFF;
         end
         o_rd_data <= 16'hFFFF;
      end else if (i_ce) begin
         if (i_clr) begin
            for (int k = 0; k < WORDS; k++) begin
               mem_q[k] <= 16'hFFFF;
            end
         end else if (i_wr) begin
            mem_q[i_idx] <= i_data;
         end
         o_rd_data <= mem_q[i_rd_idx];
      end
   end
endmodule // spfa_page_buf

// ==== hdl/spfa_ctrl.sv ====
/*
 * Self-programming front end: control register, timed store window, page
 * erase/write timer on oscillator ticks, region busy tracking, read gating.
 * Assumes the core presents the pointer with its store/load strobes and that
 * the flash array itself sits outside; i_osc_tick pulses once per 1 us.
 */
`timescale 1ns/1ps
module spfa_ctrl #(
   parameter int PROG_TICKS = spfa_pkg::PROG_TICKS
) (
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_ce,             // freezes all state when low
   input  wire logic        i_por,            // supply-loss reset, aborts programming
   input  wire logic        i_boot_size_sel_hi,
   input  wire logic        i_boot_size_sel_lo,
   input  wire logic        i_osc_tick,       // calibrated oscillator tick
   input  wire logic        i_ctrl_wr,        // control register write strobe
   input  wire logic [7:0]  i_ctrl_wdata,     // control register data
   input  wire logic        i_eeprom_write_active,
   input  wire logic        i_store,          // store to program memory
   input  wire logic        i_load,           // load from program memory
   input  wire logic [15:0] i_ptr,            // address pointer
   input  wire logic [15:0] i_store_data,     // r0
   input  wire logic [15:0] i_flash_word,     // word read from the array
   input  wire logic [12:0] i_fetch_addr,     // instruction fetch word address
   output logic      [7:0]  o_ctrl_rdata,     // control register readback
   output logic             o_selfprog_op_enable,
   output logic             o_rww_region_busy_flag,
   output logic      [12:0] o_boot_start,     // first boot word
   output logic      [12:0] o_app_end,        // last application word
   output logic             o_prog_active,    // erase or write running
   output logic             o_prog_erase,     // 1 erase, 0 write
   output logic      [6:0]  o_prog_page,      // page under programming
   output logic      [12:0] o_read_addr,      // word address to the array
   output logic      [7:0]  o_load_byte,      // selected byte of a load
   output logic             o_load_valid,
   output logic             o_read_blocked,   // load/fetch hit a busy region
   output logic             o_cpu_halt,       // fetch stalled by programming
   output logic      [15:0] o_buf_word        // buffer word at pointer
);
   // =====================================================
   // state
   typedef enum logic [2:0] {
      SPFA_IDLE  = 3'b001,
      SPFA_ARMED = 3'b010,
      SPFA_PROG  = 3'b100
   } spfa_state_t;

   typedef struct packed {
      spfa_state_t st;       // sequencer state
      logic [7:0]  ctrl;     // selfprog_control_reg low bits
      logic [2:0]  win;      // cycles left for the store
      logic        busy;     // rww_region_busy_flag
      logic        erase;    // current operation kind
      logic [6:0]  page;     // page under programming
      logic        blocked_during_write_region_op;  // target page in blocked region
      logic [15:0] ticks;    // oscillator ticks elapsed
      logic [7:0]  ld_byte;  // load result
      logic        ld_vld;   // load result valid
   } spfa_regs_t;

   spfa_regs_t r_q, r_d;

   // =====================================================
   // decoding helpers
   // boot decode
   function automatic logic [12:0] boot_start(input logic hi, input logic lo);
      case ({hi, lo})
         2'b11:   boot_start = spfa_pkg::BOOT_START_128;
         2'b10:   boot_start = spfa_pkg::BOOT_START_256;
         2'b01:   boot_start = spfa_pkg::BOOT_START_512;
         default: boot_start = spfa_pkg::BOOT_START_1024;
      endcase
   endfunction

   function automatic logic in_rww(input logic [12:0] a);
      in_rww = (a < spfa_pkg::BLOCKED_DURING_WRITE_REGION_START);
   endfunction

   // pointer bits 15:14 dropped, bit 0 dropped
   logic [12:0] ptr_word;
   logic [6:0]  page_index;
   logic [5:0]  word_in_page_index;
   assign ptr_word           = i_ptr[spfa_pkg::PTR_TOP:spfa_pkg::PTR_WORD_LO];
   assign page_index         = i_ptr[spfa_pkg::PTR_TOP:spfa_pkg::PTR_PAGE_LO];
   assign word_in_page_index = i_ptr[spfa_pkg::PTR_WORD_TOP:spfa_pkg::PTR_WORD_LO];

   // =====================================================
   // command decode of the armed pattern
   logic is_erase, is_write, is_load, is_reen, is_lock, store_go, prog_done, buf_wr, buf_clr;
   assign is_erase = (r_q.ctrl[6:0] == spfa_pkg::CMD_ERASE);
   assign is_write = (r_q.ctrl[6:0] == spfa_pkg::CMD_WRITE);
   assign is_load  = (r_q.ctrl == spfa_pkg::CMD_LOAD);
   assign is_reen  = (r_q.ctrl[6:0] == spfa_pkg::CMD_REEN);
   assign is_lock  = (r_q.ctrl[6:0] == spfa_pkg::CMD_LOCKSET);
   assign store_go = (r_q.st == SPFA_ARMED) && i_store;
   assign prog_done = (r_q.st == SPFA_PROG) && (r_q.ticks >= 16'(PROG_TICKS - 1)) && i_osc_tick;
   assign buf_wr  = i_ce && store_go && is_load;
   // buffer auto erase after write or lock write, also on reenable
   assign buf_clr = i_ce && (((r_q.st == SPFA_PROG) && prog_done && !r_q.erase) || (store_go && is_reen));

   // =====================================================
   // next-state logic
   always_comb begin
      r_d        = r_q;
      r_d.ld_vld = 1'b0;
      case (r_q.st)
         SPFA_IDLE: begin
            // eeprom write blocks the control register
            if (i_ctrl_wr && !i_eeprom_write_active && i_ctrl_wdata[spfa_pkg::ENABLE_BIT]) begin
               r_d.ctrl = i_ctrl_wdata;
               r_d.win  = 3'(spfa_pkg::CMD_WINDOW);
               r_d.st   = SPFA_ARMED;
            end
         end
         SPFA_ARMED: begin
            if (store_go) begin
               r_d.ctrl = 8'h00;
               r_d.st   = SPFA_IDLE;
               if (is_erase || is_write || is_lock) begin
                  r_d.ctrl    = r_q.ctrl;
                  r_d.st      = SPFA_PROG;
                  r_d.erase   = is_erase;
                  r_d.page    = page_index;
                  r_d.blocked_during_write_region_op = !in_rww({page_index, 6'h00});
                  r_d.ticks   = 16'h0000;
                  // lock writes leave the region readable
                  r_d.busy    = r_q.busy || !is_lock;
               end
               if (is_reen) begin
                  r_d.busy = 1'b0;
               end
            end else if (r_q.win == 3'h1) begin
               // window lapsed, enable falls
               r_d.ctrl = 8'h00;
               r_d.st   = SPFA_IDLE;
            end else begin
               r_d.win = r_q.win - 3'h1;
            end
         end
         SPFA_PROG: begin
            if (i_osc_tick) begin
               r_d.ticks = r_q.ticks + 16'h0001;
            end
            // enable self clears at the end
            if (prog_done) begin
               r_d.ctrl = 8'h00;
               r_d.st   = SPFA_IDLE;
            end
         end
         default: begin
            r_d.st = SPFA_IDLE;
         end
      endcase
      if (i_load) begin
         r_d.ld_byte = i_ptr[spfa_pkg::PTR_BYTE_SEL] ? i_flash_word[15:8] : i_flash_word[7:0];
         r_d.ld_vld  = !(o_prog_active && in_rww(ptr_word));
      end
   end

   // =====================================================
   // state register; system reset spares a running program
   always_ff @(posedge i_clk or posedge i_por) begin
      if (i_por) begin
         r_q    <= '0;
         r_q.st <= SPFA_IDLE;
      end else if (i_ce) begin
         if (i_sys_rst && (r_q.st != SPFA_PROG)) begin
            r_q    <= '0;
            r_q.st <= SPFA_IDLE;
         end else begin
            r_q <= r_d;
         end
      end
   end

   // =====================================================
   // temporary page buffer
   spfa_page_buf u_buf (
      .i_clk     (i_clk),
      .i_sys_rst (i_por),
      .i_ce      (i_ce),
      .i_wr      (buf_wr),
      .i_clr     (buf_clr),
      .i_idx     (word_in_page_index),
      .i_data    (i_store_data),
      .i_rd_idx  (word_in_page_index),
      .o_rd_data (o_buf_word)
   );

   // =====================================================
   // outputs
   assign o_ctrl_rdata           = {r_q.ctrl[7], r_q.busy, r_q.ctrl[5:0]};
   assign o_selfprog_op_enable   = r_q.ctrl[spfa_pkg::ENABLE_BIT];
   assign o_rww_region_busy_flag = r_q.busy;
   assign o_boot_start           = boot_start(i_boot_size_sel_hi, i_boot_size_sel_lo);
   assign o_app_end              = o_boot_start - 13'h0001;
   assign o_prog_active          = (r_q.st == SPFA_PROG) && (r_q.ctrl[6:0] != spfa_pkg::CMD_LOCKSET);
   assign o_prog_erase           = r_q.erase;
   assign o_prog_page            = r_q.page;
   assign o_read_addr            = ptr_word;
   assign o_load_byte            = r_q.ld_byte;
   assign o_load_valid           = r_q.ld_vld;
   // gate reads of the readable region while programming
   assign o_read_blocked = o_prog_active && ((i_load && in_rww(ptr_word)) || in_rww(i_fetch_addr));
   assign o_cpu_halt     = o_prog_active && (r_q.blocked_during_write_region_op || in_rww(i_fetch_addr));

   // =====================================================
   // checks
   property p_busy_hold;
      @(posedge i_clk) disable iff (i_por || i_sys_rst)
      (r_q.busy && i_ce && !(store_go && is_reen)) |=> r_q.busy;
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy flag dropped without reenable");

   property p_en_clears;
      @(posedge i_clk) disable iff (i_por || i_sys_rst)
      (i_ce && prog_done) |=> !o_selfprog_op_enable;
   endproperty
   a_en_clears: assert property (p_en_clears) else $error("enable did not clear after program");

   property p_erase_sets_busy;
      @(posedge i_clk) disable iff (i_por || i_sys_rst)
      (i_ce && store_go && is_erase) |=> (o_prog_active && r_q.busy && o_prog_erase);
   endproperty
   a_erase_sets_busy: assert property (p_erase_sets_busy) else $error("erase did not start");

   property p_page_idx;
      @(posedge i_clk) disable iff (i_por || i_sys_rst)
      (i_ce && store_go && is_write) |=> (o_prog_page == $past(i_ptr[13:7]));
   endproperty
   a_page_idx: assert property (p_page_idx) else $error("page index wrong");

   property p_block;
      @(posedge i_clk) disable iff (i_por || i_sys_rst)
      (o_prog_active && i_load && i_ptr[13:1] < 13'h1C00) |-> o_read_blocked;
   endproperty
   a_block: assert property (p_block) else $error("readable region not blocked");

   property p_byte_sel;
      @(posedge i_clk) disable iff (i_por || i_sys_rst)
      (i_ce && i_load && i_ptr[0]) |=> (o_load_byte == $past(i_flash_word[15:8]));
   endproperty
   a_byte_sel: assert property (p_byte_sel) else $error("byte select wrong");

   property p_boot;
      @(posedge i_clk) disable iff (i_por)
      (!i_boot_size_sel_hi && !i_boot_size_sel_lo) |-> (o_boot_start == 13'h1C00 && o_app_end == 13'h1BFF);
   endproperty
   a_boot: assert property (p_boot) else $error("boot decode wrong");

   property p_min_time;
      @(posedge i_clk) disable iff (i_por)
      (i_ce && (r_q.st == SPFA_PROG) && (r_d.st != SPFA_PROG)) |-> (r_q.ticks == 16'(PROG_TICKS - 1) && i_osc_tick);
   endproperty
   a_min_time: assert property (p_min_time) else $error("program ended early");

   property p_reset_survive;
      @(posedge i_clk) disable iff (i_por)
      (i_ce && i_sys_rst && o_prog_active && !prog_done) |=> o_prog_active;
   endproperty
   a_reset_survive: assert property (p_reset_survive) else $error("reset aborted programming");
endmodule // spfa_ctrl

// ==== bench/spfa_core_model.sv ====
/*
 * Core model: timed control write then store, loads and pointer moves.
 * Assumes callers sit on a falling edge; the design samples on the rising one.
 */
`timescale 1ns/1ps
module spfa_core_model (
   input  wire logic        i_clk,
   input  wire logic        i_op_enable,            // previous command running
   input  wire logic        i_eeprom_write_active,  // eeprom write busy
   output logic             o_ctrl_wr,              // control write strobe
   output logic      [7:0]  o_ctrl_wdata,           // control pattern
   output logic             o_store,                // store strobe
   output logic             o_load,                 // load strobe
   output logic      [15:0] o_ptr,                  // address pointer
   output logic      [15:0] o_store_data            // r0
);
   // =====================================================
   // state
   int hang_count = 0;   // idle waits that ran out
   initial begin
      o_ctrl_wr    = 1'b0;
      o_ctrl_wdata = 8'h00;
      o_store      = 1'b0;
      o_load       = 1'b0;
      o_ptr        = 16'h3FFE;
      o_store_data = 16'h0000;
   end
   // =====================================================
   // timed sequence; a gap above three makes the store late on purpose
   task automatic spm(input logic [7:0] cmd, input logic [15:0] p, input logic [15:0] d,
                      input int gap, input bit skip_ee);
      int n;
      for (n = 0; n < 6000 && (i_op_enable !== 1'b0 ||
           (!skip_ee && i_eeprom_write_active !== 1'b0)); n++) begin
         @(negedge i_clk);
      end
      if (n == 6000) begin
         hang_count++;
      end
      o_ctrl_wdata = cmd;
      o_ctrl_wr    = 1'b1;
      // zero word index and byte bit for a write, only the byte bit otherwise
      o_ptr        = (cmd[6:0] == 7'h05) ? {p[15:7], 7'h00} : {p[15:1], 1'b0};
      o_store_data = d;
      @(negedge i_clk);
      o_ctrl_wr    = 1'b0;
      o_ctrl_wdata = ~cmd;   // released, no stale value
      repeat (gap) @(negedge i_clk);
      o_store      = 1'b1;
      @(negedge i_clk);
      o_store      = 1'b0;
      o_store_data = ~d;
   endtask
   // =====================================================
   // one load strobe; the pointer stays put afterwards
   task automatic lpm(input logic [15:0] p);
      o_ptr  = p;
      o_load = 1'b1;
      @(negedge i_clk);
      o_load = 1'b0;
   endtask
   task automatic point(input logic [15:0] p);
      o_ptr = p;
   endtask
endmodule // spfa_core_model

// ==== bench/tb.sv ====
/*
 * Self-checking bench for spfa_ctrl: fuse decode, pointer split, buffer fill,
 * erase and write timing, read gating, reset in mid-write.
 * Assumes 20 MHz clock and a shortened programming tick count.
 */
`timescale 1ns/1ps
module tb;
   // =====================================================
   // stimulus and observation
   localparam int PT = 10;                  // shortened tick count
   logic        i_clk       = 1'b0;
   logic        i_sys_rst   = 1'b1;
   logic        i_por       = 1'b1;
   logic [1:0]  fuse        = 2'b11;        // hi, lo
   logic        tick        = 1'b0;
   logic        tick_en     = 1'b1;         // low stalls the oscillator
   logic        ce          = 1'b1;         // low freezes the design
   logic        ee          = 1'b0;
   logic [15:0] flash_word  = 16'h0000;
   logic [12:0] fetch       = 13'h1FFF;     // boot code running
   logic [4:0]  tdiv        = 5'h00;
   logic [31:0] rng         = 32'h0000001B;
   int          err_count   = 0;
   int          comparisons = 0;
   int          tick_cnt    = 0;
   logic        ctrl_wr, store, load, en, busy, act, ers, lvalid, blocked, halt;
   logic [7:0]  ctrl_wdata, rdata, lbyte;
   logic [15:0] ptr, sdata, bufw;
   logic [12:0] boot_start, app_end, raddr;
   logic [6:0]  page;
   always #25 i_clk = ~i_clk;
   // one oscillator tick every 20 clocks
   always @(negedge i_clk) begin
      tdiv <= (tdiv == 5'h13) ? 5'h00 : tdiv + 5'h01;
      tick <= tick_en && (tdiv == 5'h13);
   end
   always @(posedge i_clk) begin
      if (act === 1'b1 && tick) begin
         tick_cnt++;
      end
   end
   spfa_ctrl #(.PROG_TICKS(PT)) u_spfa_ctrl (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(ce), .i_por(i_por),
      .i_boot_size_sel_hi(fuse[1]), .i_boot_size_sel_lo(fuse[0]), .i_osc_tick(tick),
      .i_ctrl_wr(ctrl_wr), .i_ctrl_wdata(ctrl_wdata), .i_eeprom_write_active(ee),
      .i_store(store), .i_load(load), .i_ptr(ptr), .i_store_data(sdata),
      .i_flash_word(flash_word), .i_fetch_addr(fetch), .o_ctrl_rdata(rdata),
      .o_selfprog_op_enable(en), .o_rww_region_busy_flag(busy), .o_boot_start(boot_start),
      .o_app_end(app_end), .o_prog_active(act), .o_prog_erase(ers), .o_prog_page(page),
      .o_read_addr(raddr), .o_load_byte(lbyte), .o_load_valid(lvalid),
      .o_read_blocked(blocked), .o_cpu_halt(halt), .o_buf_word(bufw));
   spfa_core_model u_spfa_core_model (
      .i_clk(i_clk), .i_op_enable(en), .i_eeprom_write_active(ee), .o_ctrl_wr(ctrl_wr),
      .o_ctrl_wdata(ctrl_wdata), .o_store(store), .o_load(load), .o_ptr(ptr),
      .o_store_data(sdata));
   // =====================================================
   // helpers
   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction
   function automatic logic [12:0] boot_exp(input logic [1:0] f);
      logic [13:0] t;
      t = 14'h2000 - (14'h0080 << (2'h3 - f));
      return t[12:0];
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t ns: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic step(input int k);
      repeat (k) @(negedge i_clk);
   endtask
   task automatic end_of_test();
      err_count += u_spfa_core_model.hang_count;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // bounded wait for the running command to finish
   task automatic wait_idle();
      int n;
      for (n = 0; n < 4000 && (act !== 1'b0 || en !== 1'b0); n++) begin
         @(negedge i_clk);
      end
      if (n == 4000) begin
         err_count++;
         $display("[FAIL] %0t ns: command never finished", $time);
         end_of_test();
      end
   endtask
   // valid may land on either of the next two edges
   task automatic load_seen(output logic v, output logic [7:0] b);
      v = (lvalid === 1'b1);
      b = lbyte;
      @(negedge i_clk);
      if (!v && lvalid === 1'b1) begin
         v = 1'b1;
         b = lbyte;
      end
   endtask
   task automatic prog(input logic [7:0] cmd, input logic [15:0] p);
      tick_cnt = 0;
      u_spfa_core_model.spm(cmd, p, 16'h0000, 0, 1'b0);
      step(1);
   endtask
   task automatic reen();
      u_spfa_core_model.spm(8'h11, 16'h0000, 16'h0000, 1, 1'b0);
      wait_idle();
   endtask
   // =====================================================
   // main sequence
   initial begin
      logic        v;
      logic [7:0]  b;
      logic [15:0] p;
      logic [31:0] r;
      int          i;
      step(3);
      i_por = 1'b0;
      i_sys_rst = 1'b0;
      step(1);
      chk(rdata, 8'h00, "control after reset");
      chk(bufw, 16'hFFFF, "buffer after reset");
      for (i = 0; i < 4; i++) begin
         fuse = i[1:0];
         step(1);
         chk(boot_start, boot_exp(i[1:0]), "boot start");
         chk(app_end, boot_exp(i[1:0]) - 13'h0001, "application end");
      end
      $display("done: fuse decode");
      for (i = 0; i < 8; i++) begin
         r = xs();
         p = r[15:0];
         flash_word = r[31:16];
         u_spfa_core_model.lpm(p);
         chk(raddr, p[13:1], "read address");
         load_seen(v, b);
         chk(v, 1'b1, "load valid");
         chk(b, p[0] ? flash_word[15:8] : flash_word[7:0], "load byte");
      end
      $display("done: pointer split and loads");
      for (i = 0; i < 8; i++) begin
         r = xs();
         p = {9'h000, 6'((i * 9) % 64), 1'b0};
         u_spfa_core_model.spm(8'h01, p, r[15:0], int'(r[17:16]), 1'b0);
         wait_idle();
         u_spfa_core_model.point(p);
         step(2);
         chk(bufw, r[15:0], "buffer word");
      end
      $display("done: buffer fill");
      prog(8'h85, 16'h0280);
      chk(act, 1'b1, "write running");
      chk(ers, 1'b0, "write kind");
      chk(page, 7'h05, "write page");
      chk(busy, 1'b1, "busy during write");
      chk(rdata, 8'hC5, "control during write");
      for (i = 0; i < 4; i++) begin
         fetch = (i < 2) ? 13'h1BFF * i[0] : 13'h1C00 + 13'h03FF * i[0];
         step(1);
         chk(blocked, i < 2, "fetch gating");
         chk(halt, i < 2, "fetch halt");
      end
      fetch = 13'h1FFF;
      u_spfa_core_model.lpm(16'h0100);
      load_seen(v, b);
      chk(v, 1'b0, "load from busy region");
      wait_idle();
      chk(tick_cnt, PT, "write length in ticks");
      chk(busy, 1'b1, "busy after write");
      u_spfa_core_model.point(16'h0012);
      step(2);
      chk(bufw, 16'hFFFF, "buffer after write");
      reen();
      chk(busy, 1'b0, "busy after reenable");
      $display("done: page write");
      prog(8'h03, 16'h3F80);
      chk(ers, 1'b1, "erase kind");
      chk(page, 7'h7F, "erase page");
      chk(halt, 1'b1, "halt on blocked-region erase");
      tick_en <= 1'b0;
      step(300);
      chk(act, 1'b1, "erase held without ticks");
      tick_en <= 1'b1;
      wait_idle();
      chk(tick_cnt, PT, "erase length in ticks");
      reen();
      $display("done: page erase");
      prog(8'h09, 16'h0001);
      chk(en, 1'b1, "lock write running");
      chk(act, 1'b0, "lock write leaves reads open");
      chk(busy, 1'b0, "lock write busy");
      step(100);
      chk(en, 1'b1, "lock write still running");
      wait_idle();
      $display("done: lock write");
      u_spfa_core_model.spm(8'h03, 16'h0400, 16'h0000, 6, 1'b0);
      step(2);
      chk(act, 1'b0, "late store");
      wait_idle();
      ee = 1'b1;
      u_spfa_core_model.spm(8'h03, 16'h0400, 16'h0000, 0, 1'b1);
      step(2);
      chk(act, 1'b0, "store with eeprom busy");
      chk(en, 1'b0, "enable with eeprom busy");
      ee = 1'b0;
      ce = 1'b0;
      u_spfa_core_model.spm(8'h03, 16'h0400, 16'h0000, 0, 1'b0);
      step(2);
      chk(en, 1'b0, "command while frozen");
      ce = 1'b1;
      $display("done: refusals");
      prog(8'h05, 16'h0100);
      step(3);
      i_sys_rst = 1'b1;
      step(3);
      i_sys_rst = 1'b0;
      chk(act, 1'b1, "write through reset");
      wait_idle();
      chk(tick_cnt, PT, "write length after reset");
      reen();
      $display("done: reset in write");
      end_of_test();
   end
endmodule // tb
